//--- hw/gmp_pkg.sv
// constants for the multi-port gpio block: addresses, widths, reset values
package gmp_pkg;
	localparam int GMP_ADDR_W = 16;
	localparam int GMP_DATA_W = 8;
	localparam int GMP_BITSEL_W = 3;

	// port widths
	localparam int GMP_P0_W = 4;
	localparam int GMP_P1_W = 8;
	localparam int GMP_P2_W = 4;
	localparam int GMP_P3_W = 4;
	localparam int GMP_P12_W = 1;
	localparam int GMP_PULLUP_COUNT = GMP_P0_W + GMP_P1_W + GMP_P3_W + GMP_P12_W;

	// port latch / level registers
	localparam logic [15:0] GMP_ADDR_FIRST_LATCH = 16'hff00;
	localparam logic [15:0] GMP_ADDR_SECOND_LATCH = 16'hff01;
	localparam logic [15:0] GMP_ADDR_INPUT_LEVELS = 16'hff02;
	localparam logic [15:0] GMP_ADDR_FOURTH_LATCH = 16'hff03;
	localparam logic [15:0] GMP_ADDR_FIFTH_LATCH = 16'hff0c;
	localparam logic [15:0] GMP_ADDR_OUTONLY_LATCH = 16'hff0d;

	// direction registers
	localparam logic [15:0] GMP_ADDR_FIRST_DIR = 16'hff20;
	localparam logic [15:0] GMP_ADDR_SECOND_DIR = 16'hff21;
	localparam logic [15:0] GMP_ADDR_FOURTH_DIR = 16'hff23;
	localparam logic [15:0] GMP_ADDR_FIFTH_DIR = 16'hff2c;

	// pull-up enable registers
	localparam logic [15:0] GMP_ADDR_FIRST_PU = 16'hff30;
	localparam logic [15:0] GMP_ADDR_SECOND_PU = 16'hff31;
	localparam logic [15:0] GMP_ADDR_FOURTH_PU = 16'hff33;
	localparam logic [15:0] GMP_ADDR_FIFTH_PU = 16'hff3c;

	// reset values
	localparam logic [7:0] GMP_DIR_RESET = 8'hff;
	localparam logic [7:0] GMP_LATCH_RESET = 8'h00;
	localparam logic [7:0] GMP_PU_RESET = 8'h00;
	localparam logic [7:0] GMP_UNMAPPED_READ = 8'h00;

	// direction bit encoding
	localparam logic GMP_DIR_OUTPUT = 1'b0;
	localparam logic GMP_DIR_INPUT = 1'b1;
endpackage

//--- hw/gmp_sync2.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module gmp_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // gmp_sync2
`default_nettype wire

//--- hw/gmp_pin_drive.sv
// per-bit pin driver, pull-up gating and read-back selection
`timescale 1ns/1ps
`default_nettype none
module gmp_pin_drive
	import gmp_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] pu_en,
	input wire logic [WIDTH-1:0] pin_level,
	output logic [WIDTH-1:0] pin_o,
	output logic [WIDTH-1:0] pin_oe,
	output logic [WIDTH-1:0] pu_on,
	output logic [WIDTH-1:0] readback
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// latch always reaches the pad; only the enable gates it
			assign pin_o[i] = latch[i];
			assign pin_oe[i] = (dir[i] == GMP_DIR_OUTPUT); // see RULE_15
			assign pu_on[i] = pu_en[i] & (dir[i] == GMP_DIR_INPUT); // see RULE_21
			assign readback[i] = (dir[i] == GMP_DIR_INPUT) ? pin_level[i] : latch[i]; // see RULE_20
		end
	endgenerate
endmodule // gmp_pin_drive
`default_nettype wire

//--- hw/gmp_ports.sv
// six-port gpio block with direction, latch and pull-up registers
// Operation
// RULE_01: first port: four bidirectional pins, per-bit direction
// RULE_02: first port per-bit pull-up enable register
// RULE_03: reset puts first port in input mode
// RULE_04: second port: eight bidirectional pins with pull-ups
// RULE_05: reset puts second port in input mode
// RULE_06: software leaves serial registers at default
// RULE_07: third port: four input-only pins, reads levels
// RULE_08: fourth port: four bidirectional pins with pull-ups
// RULE_09: reset puts fourth port in input mode
// RULE_10: fifth port: one bidirectional pin with pull-up
// RULE_11: reset puts fifth port in input mode
// RULE_12: sixth port: one always-driven output-only pin
// RULE_13: output-only pin drives low during reset
// RULE_14: direction registers reset to all ones
// RULE_15: direction 0 drives, 1 releases pin
// RULE_16: direction registers accept bit and byte writes
// RULE_17: software sets direction 1 for alternate inputs
// RULE_18: software sets direction/latch for alternate outputs
// RULE_19: exactly seventeen software-only pull-ups
// RULE_20: read gives pin in input, latch in output
// RULE_21: pull-up only when enabled and input mode
// RULE_22: reset clears latches and pull-up enables
// RULE_23: write in input mode retains latch only
// RULE_24: unimplemented direction bits read one, ignore writes
`timescale 1ns/1ps
`default_nettype none
module gmp_ports
	import gmp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	// processor register port
	input wire logic [GMP_ADDR_W-1:0] SFR_ADDR,
	input wire logic [GMP_DATA_W-1:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_BIT_WR,
	input wire logic [GMP_BITSEL_W-1:0] SFR_BIT_SEL,
	input wire logic SFR_RD,
	output logic [GMP_DATA_W-1:0] SFR_RDATA,
	output logic SFR_RVALID,
	// first port
	input wire logic [GMP_P0_W-1:0] FIRST_PORT_PIN_I,
	output logic [GMP_P0_W-1:0] FIRST_PORT_PIN_O,
	output logic [GMP_P0_W-1:0] FIRST_PORT_PIN_OE,
	output logic [GMP_P0_W-1:0] FIRST_PORT_PULLUP,
	// second port
	input wire logic [GMP_P1_W-1:0] SECOND_PORT_PIN_I,
	output logic [GMP_P1_W-1:0] SECOND_PORT_PIN_O,
	output logic [GMP_P1_W-1:0] SECOND_PORT_PIN_OE,
	output logic [GMP_P1_W-1:0] SECOND_PORT_PULLUP,
	// input-only port, shared with analog inputs
	input wire logic [GMP_P2_W-1:0] INPUT_ONLY_PIN_I,
	// fourth port
	input wire logic [GMP_P3_W-1:0] FOURTH_PORT_PIN_I,
	output logic [GMP_P3_W-1:0] FOURTH_PORT_PIN_O,
	output logic [GMP_P3_W-1:0] FOURTH_PORT_PIN_OE,
	output logic [GMP_P3_W-1:0] FOURTH_PORT_PULLUP,
	// fifth port
	input wire logic [GMP_P12_W-1:0] FIFTH_PORT_PIN_I,
	output logic [GMP_P12_W-1:0] FIFTH_PORT_PIN_O,
	output logic [GMP_P12_W-1:0] FIFTH_PORT_PIN_OE,
	output logic [GMP_P12_W-1:0] FIFTH_PORT_PULLUP,
	// output-only pin
	output logic OUTPUT_ONLY_PIN
);

	////////////////////////////////////////////////////////////////////////////////
	// write decode

	logic any_wr;
	logic [7:0] wr_bitmask;
	logic [7:0] wr_bitval;

	assign any_wr = SFR_WR | SFR_BIT_WR;
	// bit writes touch only the selected bit; byte writes replace all
	assign wr_bitmask = SFR_WR ? 8'hff : (8'h01 << SFR_BIT_SEL); // see RULE_16
	assign wr_bitval = SFR_WR ? SFR_WDATA : {8{SFR_WDATA[0]}};

	function automatic logic [7:0] merge_write(input logic [7:0] cur);
		merge_write = (cur & ~wr_bitmask) | (wr_bitval & wr_bitmask);
	endfunction

	logic sel_first_latch;
	logic sel_second_latch;
	logic sel_input_levels;
	logic sel_fourth_latch;
	logic sel_fifth_latch;
	logic sel_outonly_latch;
	logic sel_first_dir;
	logic sel_second_dir;
	logic sel_fourth_dir;
	logic sel_fifth_dir;
	logic sel_first_pu;
	logic sel_second_pu;
	logic sel_fourth_pu;
	logic sel_fifth_pu;

	assign sel_first_latch = (SFR_ADDR == GMP_ADDR_FIRST_LATCH);
	assign sel_second_latch = (SFR_ADDR == GMP_ADDR_SECOND_LATCH);
	assign sel_input_levels = (SFR_ADDR == GMP_ADDR_INPUT_LEVELS);
	assign sel_fourth_latch = (SFR_ADDR == GMP_ADDR_FOURTH_LATCH);
	assign sel_fifth_latch = (SFR_ADDR == GMP_ADDR_FIFTH_LATCH);
	assign sel_outonly_latch = (SFR_ADDR == GMP_ADDR_OUTONLY_LATCH);
	assign sel_first_dir = (SFR_ADDR == GMP_ADDR_FIRST_DIR);
	assign sel_second_dir = (SFR_ADDR == GMP_ADDR_SECOND_DIR);
	assign sel_fourth_dir = (SFR_ADDR == GMP_ADDR_FOURTH_DIR);
	assign sel_fifth_dir = (SFR_ADDR == GMP_ADDR_FIFTH_DIR);
	assign sel_first_pu = (SFR_ADDR == GMP_ADDR_FIRST_PU);
	assign sel_second_pu = (SFR_ADDR == GMP_ADDR_SECOND_PU);
	assign sel_fourth_pu = (SFR_ADDR == GMP_ADDR_FOURTH_PU);
	assign sel_fifth_pu = (SFR_ADDR == GMP_ADDR_FIFTH_PU);

	////////////////////////////////////////////////////////////////////////////////
	// output latches

	logic [GMP_P0_W-1:0] first_port_latch_q;
	logic [GMP_P1_W-1:0] second_port_latch_q;
	logic [GMP_P3_W-1:0] fourth_port_latch_q;
	logic [GMP_P12_W-1:0] fifth_port_latch_q;
	logic output_only_port_latch_q;

	// latches update regardless of direction; the pad only sees them in output mode
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			first_port_latch_q <= GMP_LATCH_RESET[GMP_P0_W-1:0]; // see RULE_22
		end else if (any_wr && sel_first_latch) begin
			first_port_latch_q <= GMP_P0_W'(merge_write({4'h0, first_port_latch_q})); // see RULE_23
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			second_port_latch_q <= GMP_LATCH_RESET[GMP_P1_W-1:0]; // see RULE_22
		end else if (any_wr && sel_second_latch) begin
			second_port_latch_q <= merge_write(second_port_latch_q); // see RULE_23
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fourth_port_latch_q <= GMP_LATCH_RESET[GMP_P3_W-1:0]; // see RULE_22
		end else if (any_wr && sel_fourth_latch) begin
			fourth_port_latch_q <= GMP_P3_W'(merge_write({4'h0, fourth_port_latch_q})); // see RULE_23
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fifth_port_latch_q <= GMP_LATCH_RESET[GMP_P12_W-1:0]; // see RULE_22
		end else if (any_wr && sel_fifth_latch) begin
			fifth_port_latch_q <= GMP_P12_W'(merge_write({7'h00, fifth_port_latch_q})); // see RULE_23
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			output_only_port_latch_q <= GMP_LATCH_RESET[0]; // see RULE_22
		end else if (any_wr && sel_outonly_latch) begin
			output_only_port_latch_q <= 1'(merge_write({7'h00, output_only_port_latch_q}));
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// direction registers

	logic [GMP_P0_W-1:0] first_port_direction_q;
	logic [GMP_P1_W-1:0] second_port_direction_q;
	logic [GMP_P3_W-1:0] fourth_port_direction_q;
	logic [GMP_P12_W-1:0] fifth_port_direction_q;

	// only implemented bits are stored; the rest are constant ones on read
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			first_port_direction_q <= GMP_DIR_RESET[GMP_P0_W-1:0]; // see RULE_03, see RULE_14
		end else if (any_wr && sel_first_dir) begin
			first_port_direction_q <= GMP_P0_W'(merge_write({4'hf, first_port_direction_q})); // see RULE_16
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			second_port_direction_q <= GMP_DIR_RESET[GMP_P1_W-1:0]; // see RULE_05, see RULE_14
		end else if (any_wr && sel_second_dir) begin
			second_port_direction_q <= merge_write(second_port_direction_q); // see RULE_16
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fourth_port_direction_q <= GMP_DIR_RESET[GMP_P3_W-1:0]; // see RULE_09, see RULE_14
		end else if (any_wr && sel_fourth_dir) begin
			fourth_port_direction_q <= GMP_P3_W'(merge_write({4'hf, fourth_port_direction_q})); // see RULE_16
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fifth_port_direction_q <= GMP_DIR_RESET[GMP_P12_W-1:0]; // see RULE_11, see RULE_14
		end else if (any_wr && sel_fifth_dir) begin
			fifth_port_direction_q <= GMP_P12_W'(merge_write({7'h7f, fifth_port_direction_q})); // see RULE_16
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pull-up enable registers; 17 bits in all, software is the only source; see RULE_19

	logic [GMP_P0_W-1:0] first_port_pullup_enable_q;
	logic [GMP_P1_W-1:0] second_port_pullup_enable_q;
	logic [GMP_P3_W-1:0] fourth_port_pullup_enable_q;
	logic [GMP_P12_W-1:0] fifth_port_pullup_enable_q;

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			first_port_pullup_enable_q <= GMP_PU_RESET[GMP_P0_W-1:0]; // see RULE_22
		end else if (any_wr && sel_first_pu) begin
			first_port_pullup_enable_q <= GMP_P0_W'(merge_write({4'h0, first_port_pullup_enable_q})); // see RULE_02
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			second_port_pullup_enable_q <= GMP_PU_RESET[GMP_P1_W-1:0]; // see RULE_22
		end else if (any_wr && sel_second_pu) begin
			second_port_pullup_enable_q <= merge_write(second_port_pullup_enable_q); // see RULE_04
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fourth_port_pullup_enable_q <= GMP_PU_RESET[GMP_P3_W-1:0]; // see RULE_22
		end else if (any_wr && sel_fourth_pu) begin
			fourth_port_pullup_enable_q <= GMP_P3_W'(merge_write({4'h0, fourth_port_pullup_enable_q})); // see RULE_08
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			fifth_port_pullup_enable_q <= GMP_PU_RESET[GMP_P12_W-1:0]; // see RULE_22
		end else if (any_wr && sel_fifth_pu) begin
			fifth_port_pullup_enable_q <= GMP_P12_W'(merge_write({7'h00, fifth_port_pullup_enable_q})); // see RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [GMP_P0_W-1:0] first_level;
	logic [GMP_P1_W-1:0] second_level;
	logic [GMP_P2_W-1:0] input_only_port_levels;
	logic [GMP_P3_W-1:0] fourth_level;
	logic [GMP_P12_W-1:0] fifth_level;

	gmp_sync2 #(.WIDTH(GMP_P0_W)) u_sync_first (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.async_in(FIRST_PORT_PIN_I),
		.sync_out(first_level)
	);

	gmp_sync2 #(.WIDTH(GMP_P1_W)) u_sync_second (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.async_in(SECOND_PORT_PIN_I),
		.sync_out(second_level)
	);

	// no latch, no direction, no pull-up: levels only
	gmp_sync2 #(.WIDTH(GMP_P2_W)) u_sync_input_only (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.async_in(INPUT_ONLY_PIN_I),
		.sync_out(input_only_port_levels)
	); // see RULE_07

	gmp_sync2 #(.WIDTH(GMP_P3_W)) u_sync_fourth (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.async_in(FOURTH_PORT_PIN_I),
		.sync_out(fourth_level)
	);

	gmp_sync2 #(.WIDTH(GMP_P12_W)) u_sync_fifth (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.async_in(FIFTH_PORT_PIN_I),
		.sync_out(fifth_level)
	);

	////////////////////////////////////////////////////////////////////////////////
	// pin drivers

	logic [GMP_P0_W-1:0] first_readback;
	logic [GMP_P1_W-1:0] second_readback;
	logic [GMP_P3_W-1:0] fourth_readback;
	logic [GMP_P12_W-1:0] fifth_readback;

	gmp_pin_drive #(.WIDTH(GMP_P0_W)) u_drive_first (
		.latch(first_port_latch_q),
		.dir(first_port_direction_q),
		.pu_en(first_port_pullup_enable_q),
		.pin_level(first_level),
		.pin_o(FIRST_PORT_PIN_O),
		.pin_oe(FIRST_PORT_PIN_OE),
		.pu_on(FIRST_PORT_PULLUP),
		.readback(first_readback)
	); // see RULE_01

	gmp_pin_drive #(.WIDTH(GMP_P1_W)) u_drive_second (
		.latch(second_port_latch_q),
		.dir(second_port_direction_q),
		.pu_en(second_port_pullup_enable_q),
		.pin_level(second_level),
		.pin_o(SECOND_PORT_PIN_O),
		.pin_oe(SECOND_PORT_PIN_OE),
		.pu_on(SECOND_PORT_PULLUP),
		.readback(second_readback)
	); // see RULE_04

	gmp_pin_drive #(.WIDTH(GMP_P3_W)) u_drive_fourth (
		.latch(fourth_port_latch_q),
		.dir(fourth_port_direction_q),
		.pu_en(fourth_port_pullup_enable_q),
		.pin_level(fourth_level),
		.pin_o(FOURTH_PORT_PIN_O),
		.pin_oe(FOURTH_PORT_PIN_OE),
		.pu_on(FOURTH_PORT_PULLUP),
		.readback(fourth_readback)
	); // see RULE_08

	gmp_pin_drive #(.WIDTH(GMP_P12_W)) u_drive_fifth (
		.latch(fifth_port_latch_q),
		.dir(fifth_port_direction_q),
		.pu_en(fifth_port_pullup_enable_q),
		.pin_level(fifth_level),
		.pin_o(FIFTH_PORT_PIN_O),
		.pin_oe(FIFTH_PORT_PIN_OE),
		.pu_on(FIFTH_PORT_PULLUP),
		.readback(fifth_readback)
	); // see RULE_10

	// gated by reset so the pin goes low at once, before a clock edge clears the latch, even if the latch held a one
	assign OUTPUT_ONLY_PIN = output_only_port_latch_q & RSTN; // see RULE_12, see RULE_13

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = GMP_UNMAPPED_READ;
		if (sel_first_latch) begin
			rd_mux = {4'h0, first_readback}; // see RULE_20
		end else if (sel_second_latch) begin
			rd_mux = second_readback; // see RULE_20
		end else if (sel_input_levels) begin
			rd_mux = {4'h0, input_only_port_levels}; // see RULE_07
		end else if (sel_fourth_latch) begin
			rd_mux = {4'h0, fourth_readback}; // see RULE_20
		end else if (sel_fifth_latch) begin
			rd_mux = {7'h00, fifth_readback}; // see RULE_20
		end else if (sel_outonly_latch) begin
			rd_mux = {7'h00, output_only_port_latch_q};
		end else if (sel_first_dir) begin
			rd_mux = {4'hf, first_port_direction_q}; // see RULE_24
		end else if (sel_second_dir) begin
			rd_mux = second_port_direction_q;
		end else if (sel_fourth_dir) begin
			rd_mux = {4'hf, fourth_port_direction_q}; // see RULE_24
		end else if (sel_fifth_dir) begin
			rd_mux = {7'h7f, fifth_port_direction_q}; // see RULE_24
		end else if (sel_first_pu) begin
			rd_mux = {4'h0, first_port_pullup_enable_q};
		end else if (sel_second_pu) begin
			rd_mux = second_port_pullup_enable_q;
		end else if (sel_fourth_pu) begin
			rd_mux = {4'h0, fourth_port_pullup_enable_q};
		end else if (sel_fifth_pu) begin
			rd_mux = {7'h00, fifth_port_pullup_enable_q};
		end
	end

	// registered answer, one cycle after the read strobe
	always_ff @(posedge SYS_CLK) begin
		if (!RSTN) begin
			SFR_RDATA <= 8'h00;
			SFR_RVALID <= 1'b0;
		end else begin
			SFR_RVALID <= SFR_RD;
			if (SFR_RD) begin
				SFR_RDATA <= rd_mux;
			end
		end
	end

endmodule // gmp_ports
`default_nettype wire

//--- verification/gmp_ports_asserts.sv
// concurrent checks on the ports of the gpio block
`timescale 1ns/1ps
`default_nettype none
module gmp_ports_asserts
	import gmp_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic [GMP_ADDR_W-1:0] SFR_ADDR,
	input wire logic [GMP_DATA_W-1:0] SFR_WDATA,
	input wire logic SFR_WR,
	input wire logic SFR_BIT_WR,
	input wire logic [GMP_BITSEL_W-1:0] SFR_BIT_SEL,
	input wire logic SFR_RD,
	input wire logic [GMP_DATA_W-1:0] SFR_RDATA,
	input wire logic SFR_RVALID,
	input wire logic [GMP_P2_W-1:0] INPUT_ONLY_PIN_I,
	input wire logic [GMP_P0_W-1:0] FIRST_PORT_PIN_OE,
	input wire logic [GMP_P1_W-1:0] SECOND_PORT_PIN_O,
	input wire logic [GMP_P1_W-1:0] SECOND_PORT_PIN_OE,
	input wire logic [GMP_P1_W-1:0] SECOND_PORT_PULLUP,
	input wire logic [GMP_P0_W-1:0] FIRST_PORT_PULLUP,
	input wire logic OUTPUT_ONLY_PIN
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	a_reset_input_mode: assert property (!$past(RSTN) |-> FIRST_PORT_PIN_OE == 4'h0 && SECOND_PORT_PIN_OE == 8'h00
		&& SECOND_PORT_PULLUP == 8'h00) else $error("pins not released after reset");
	a_pullup_gated: assert property ((FIRST_PORT_PULLUP & FIRST_PORT_PIN_OE) == 4'h0
		&& (SECOND_PORT_PULLUP & SECOND_PORT_PIN_OE) == 8'h00) else $error("pull-up on a driven pin");
	a_pullup_follows: assert property (SFR_WR && SFR_ADDR == GMP_ADDR_SECOND_PU && SECOND_PORT_PIN_OE == 8'h00
		|=> SECOND_PORT_PULLUP == $past(SFR_WDATA)) else $error("pull-up enable not applied");
	a_dir_byte_write: assert property (SFR_WR && SFR_ADDR == GMP_ADDR_FIRST_DIR
		|=> FIRST_PORT_PIN_OE == ~$past(SFR_WDATA[3:0])) else $error("direction byte write wrong");
	a_dir_bit_write: assert property (SFR_BIT_WR && !SFR_WR && SFR_ADDR == GMP_ADDR_SECOND_DIR
		|=> SECOND_PORT_PIN_OE[$past(SFR_BIT_SEL)] == !$past(SFR_WDATA[0])) else $error("direction bit write wrong");
	a_latch_kept: assert property (SFR_WR && SFR_ADDR == GMP_ADDR_SECOND_LATCH
		|=> SECOND_PORT_PIN_O == $past(SFR_WDATA)) else $error("latch write not kept");
	a_dir_upper_ones: assert property (SFR_RD && SFR_ADDR == GMP_ADDR_FIRST_DIR
		|=> SFR_RVALID && SFR_RDATA[7:4] == 4'hf) else $error("unused direction bits not one");
	a_input_levels: assert property (SFR_RD && SFR_ADDR == GMP_ADDR_INPUT_LEVELS && $past(RSTN, 2)
		&& $past(INPUT_ONLY_PIN_I) == INPUT_ONLY_PIN_I && $past(INPUT_ONLY_PIN_I, 2) == INPUT_ONLY_PIN_I
		|=> SFR_RDATA == {4'h0, $past(INPUT_ONLY_PIN_I)}) else $error("input-only read wrong");
	a_outonly_reset: assert property (@(posedge SYS_CLK) disable iff (1'b0) !RSTN |-> !OUTPUT_ONLY_PIN)
		else $error("output-only pin high in reset");
	a_outonly_drive: assert property (SFR_WR && SFR_ADDR == GMP_ADDR_OUTONLY_LATCH
		|=> OUTPUT_ONLY_PIN == $past(SFR_WDATA[0])) else $error("output-only pin wrong");
endmodule // gmp_ports_asserts
bind gmp_ports gmp_ports_asserts gmp_ports_asserts_i (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .SFR_ADDR(SFR_ADDR),
	.SFR_WDATA(SFR_WDATA), .SFR_WR(SFR_WR), .SFR_BIT_WR(SFR_BIT_WR), .SFR_BIT_SEL(SFR_BIT_SEL), .SFR_RD(SFR_RD),
	.SFR_RDATA(SFR_RDATA), .SFR_RVALID(SFR_RVALID), .INPUT_ONLY_PIN_I(INPUT_ONLY_PIN_I),
	.FIRST_PORT_PIN_OE(FIRST_PORT_PIN_OE), .SECOND_PORT_PIN_O(SECOND_PORT_PIN_O),
	.SECOND_PORT_PIN_OE(SECOND_PORT_PIN_OE), .SECOND_PORT_PULLUP(SECOND_PORT_PULLUP),
	.FIRST_PORT_PULLUP(FIRST_PORT_PULLUP), .OUTPUT_ONLY_PIN(OUTPUT_ONLY_PIN));
`default_nettype wire

//--- verification/gmp_board.sv
// board model: pad level from driver, pull-up and board drive
`timescale 1ns/1ps
`default_nettype none
module gmp_board (
	input wire logic clk,
	input wire logic [16:0] pin_o,
	input wire logic [16:0] pin_oe,
	input wire logic [16:0] pu_on,
	input wire logic [16:0] ext_v,
	input wire logic [16:0] ext_en,
	output logic [16:0] pin_i
);
	logic [16:0] flt_q = 17'h0_aaaa;
	// a floating pad toggles so a stale level is never read as valid
	always @(posedge clk) flt_q <= ~flt_q;
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & ((ext_en & ext_v) | (~ext_en & (pu_on | flt_q))));
endmodule // gmp_board
`default_nettype wire

//--- verification/test_gmp_ports.sv
// self-checking bench for the gpio block
`timescale 1ns/1ps
`default_nettype none
module test_gmp_ports import gmp_pkg::*;;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic bwr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] bsel = 3'h0;
	logic [3:0] in_only = 4'h0;
	logic [16:0] ext_v = 17'h0_0000;
	logic [16:0] ext_en = 17'h1_ffff;
	wire [16:0] pin_i, pin_o, pin_oe, pu_on;
	wire [7:0] rdata;
	wire rvalid, oo;
	logic [7:0] dir_s[4], lat_s[4], pu_s[4];
	logic oo_s;
	int n_mismatch = 0;
	int compares = 0;
	int seed;
	localparam logic [7:0] msk [4] = '{8'h0f, 8'hff, 8'h0f, 8'h01};
	localparam int off [4] = '{0, 4, 12, 16};
	localparam logic [15:0] da [4] = '{GMP_ADDR_FIRST_DIR, GMP_ADDR_SECOND_DIR, GMP_ADDR_FOURTH_DIR, GMP_ADDR_FIFTH_DIR};
	localparam logic [15:0] la [4] = '{GMP_ADDR_FIRST_LATCH, GMP_ADDR_SECOND_LATCH, GMP_ADDR_FOURTH_LATCH,
		GMP_ADDR_FIFTH_LATCH};
	localparam logic [15:0] pa [4] = '{GMP_ADDR_FIRST_PU, GMP_ADDR_SECOND_PU, GMP_ADDR_FOURTH_PU, GMP_ADDR_FIFTH_PU};
	always #12.5 sys_clk = ~sys_clk;
	gmp_ports gmp_ports_i (.SYS_CLK(sys_clk), .RSTN(rstn), .SFR_ADDR(addr), .SFR_WDATA(wdata), .SFR_WR(wr),
		.SFR_BIT_WR(bwr), .SFR_BIT_SEL(bsel), .SFR_RD(rd), .SFR_RDATA(rdata), .SFR_RVALID(rvalid),
		.FIRST_PORT_PIN_I(pin_i[3:0]), .FIRST_PORT_PIN_O(pin_o[3:0]), .FIRST_PORT_PIN_OE(pin_oe[3:0]),
		.FIRST_PORT_PULLUP(pu_on[3:0]), .SECOND_PORT_PIN_I(pin_i[11:4]), .SECOND_PORT_PIN_O(pin_o[11:4]),
		.SECOND_PORT_PIN_OE(pin_oe[11:4]), .SECOND_PORT_PULLUP(pu_on[11:4]), .INPUT_ONLY_PIN_I(in_only),
		.FOURTH_PORT_PIN_I(pin_i[15:12]), .FOURTH_PORT_PIN_O(pin_o[15:12]), .FOURTH_PORT_PIN_OE(pin_oe[15:12]),
		.FOURTH_PORT_PULLUP(pu_on[15:12]), .FIFTH_PORT_PIN_I(pin_i[16]), .FIFTH_PORT_PIN_O(pin_o[16]),
		.FIFTH_PORT_PIN_OE(pin_oe[16]), .FIFTH_PORT_PULLUP(pu_on[16]), .OUTPUT_ONLY_PIN(oo));
	gmp_board gmp_board_i (.clk(sys_clk), .pin_o(pin_o), .pin_oe(pin_oe), .pu_on(pu_on), .ext_v(ext_v),
		.ext_en(ext_en), .pin_i(pin_i));
	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] nv(input logic [7:0] o, input logic [7:0] d, input logic b, input logic [2:0] s);
		nv = o;
		if (b) nv[s] = d[0];
		else nv = d;
	endfunction
	// undriven pads are only read where a pull-up holds them high
	function automatic logic [7:0] exp_rd(input logic [15:0] a);
		logic [7:0] r;
		logic [16:0] lv;
		r = 8'h00;
		lv = ext_v | ~ext_en;
		for (int k = 0; k < 4; k++) begin
			if (a == da[k]) r = dir_s[k] | ~msk[k];
			if (a == pa[k]) r = pu_s[k];
			if (a == la[k]) r = ((dir_s[k] & 8'(lv >> off[k])) | (~dir_s[k] & lat_s[k])) & msk[k];
		end
		if (a == GMP_ADDR_INPUT_LEVELS) r = {4'h0, in_only};
		if (a == GMP_ADDR_OUTONLY_LATCH) r = {7'h00, oo_s};
		return r;
	endfunction
	function automatic logic [16:0] exp_pin(input int w);
		logic [16:0] r;
		r = 17'h0_0000;
		for (int k = 0; k < 4; k++) begin
			for (int b = 0; b < 8; b++) begin
				if (msk[k][b]) r[off[k] + b] = w == 0 ? !dir_s[k][b] : w == 1 ? lat_s[k][b] : pu_s[k][b] & dir_s[k][b];
			end
		end
		return r;
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("mismatches %0d, compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: read %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [16:0] got, input logic [16:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: pins %h, wanted %h", $time, got, exp);
		end
	endtask
	task automatic chk_pins;
		chk_pin(pin_oe, exp_pin(0));
		chk_pin(pin_o, exp_pin(1));
		chk_pin(pu_on, exp_pin(2));
		chk_pin({16'h0000, oo}, {16'h0000, oo_s});
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d, input logic b, input logic [2:0] s);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		bsel <= s;
		wr <= !b;
		bwr <= b;
		@(posedge sys_clk);
		wr <= 1'b0;
		bwr <= 1'b0;
		#1;
		for (int k = 0; k < 4; k++) begin
			if (a == da[k]) dir_s[k] = nv(dir_s[k], d, b, s) | ~msk[k];
			if (a == la[k]) lat_s[k] = nv(lat_s[k], d, b, s) & msk[k];
			if (a == pa[k]) pu_s[k] = nv(pu_s[k], d, b, s) & msk[k];
		end
		if (a == GMP_ADDR_OUTONLY_LATCH && (!b || s == 3'h0)) oo_s = d[0];
		chk_pins;
	endtask
	task automatic rd_reg(input logic [15:0] a);
		int n;
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		n = 0;
		while (rvalid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		if (n == 4) begin
			n_mismatch++;
			$display("unexpected at %0t: no read answer", $time);
			end_of_test;
		end else begin
			chk_reg(rdata, exp_rd(a));
		end
	endtask
	task automatic do_reset(input int n);
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (n) @(posedge sys_clk);
		#1;
		for (int k = 0; k < 4; k++) begin
			dir_s[k] = 8'hff;
			lat_s[k] = 8'h00;
			pu_s[k] = 8'h00;
		end
		oo_s = 1'b0;
		chk_pin(pin_oe | pin_o | pu_on, 17'h0_0000);
		chk_pin({16'h0000, oo}, 17'h0_0000);
		@(posedge sys_clk);
		rstn <= 1'b1;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic [15:0] a;
		seed = 32'h9f41;
		do_reset(20);
		ext_en <= 17'h0_0000;
		for (int k = 0; k < 4; k++) begin
			rd_reg(da[k]);
			wr_reg(pa[k], 8'hff, 1'b0, 3'h0);
			rd_reg(pa[k]);
		end
		chk_pin(17'(pu_on == 17'h1_ffff), 17'h0_0001);
		for (int k = 0; k < 4; k++) begin
			rd_reg(la[k]);
			wr_reg(da[k], 8'h00, 1'b0, 3'h0);
			rd_reg(la[k]);
		end
		ext_en <= 17'h1_ffff;
		wr_reg(GMP_ADDR_INPUT_LEVELS, 8'hff, 1'b0, 3'h0);
		wr_reg(16'hff10, 8'h5a, 1'b0, 3'h0);
		rd_reg(16'hff10);
		wr_reg(GMP_ADDR_FIFTH_DIR, 8'h00, 1'b1, 3'h5);
		rd_reg(GMP_ADDR_FIFTH_DIR);
		for (int i = 0; i < 150; i++) begin
			r = $random(seed);
			@(posedge sys_clk);
			ext_v <= r[31:15];
			in_only <= r[19:16];
			case (r[3:2])
				2'd0: a = da[r[1:0]];
				2'd1: a = la[r[1:0]];
				2'd2: a = pa[r[1:0]];
				default: a = GMP_ADDR_OUTONLY_LATCH;
			endcase
			wr_reg(a, r[15:8], r[4], r[7:5]);
			// a new direction reaches the readback only after the synchroniser
			@(posedge sys_clk);
			rd_reg(a);
			rd_reg(GMP_ADDR_INPUT_LEVELS);
		end
		wr_reg(GMP_ADDR_OUTONLY_LATCH, 8'h01, 1'b0, 3'h0);
		do_reset(3);
		chk_pins;
		rd_reg(GMP_ADDR_SECOND_DIR);
		end_of_test;
	end
endmodule // test_gmp_ports
`default_nettype wire
